/* File: verilog/periph_irq_pkg.sv */
// constants of the peripheral interrupt enable block
// assumes an apb slave at 100 MHz, non-usart events are single-cycle pulses on pclk, usart events are levels
package periph_irq_pkg;
   localparam logic [11:0] OFS_ENABLE  = 12'h08C;
   localparam logic [11:0] OFS_FLAG    = 12'h00C;
   localparam logic [11:0] OFS_CONTROL = 12'h00B;
   localparam logic [11:0] OFS_BUS_IRQ_STATUS = 12'h100;
   localparam logic [11:0] OFS_BUS_IRQ_MASK   = 12'h104;
   localparam int BIT_TIMER_ONE = 0;
   localparam int BIT_TIMER_TWO = 1;
   localparam int BIT_CAPCOMP   = 2;
   localparam int BIT_SERIAL    = 3;
   localparam int BIT_UTX       = 4;
   localparam int BIT_URX       = 5;
   localparam int BIT_PAR       = 7;
   localparam int BIT_MASTER_EN = 6;
   localparam int BIT_GLOBAL_EN = 7;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET   = 8'h00;
   localparam logic [7:0] BASIC_MASK   = 8'h0F;
   localparam logic [7:0] USART_MASK   = 8'h30;
   localparam logic [7:0] PAR_MASK     = 8'h80;
   localparam logic [1:0] BUS_EVT_REQ_RISE = 2'h1;
   localparam logic [1:0] BUS_EVT_FLAG_NEW = 2'h2;
endpackage : periph_irq_pkg

/* File: verilog/irq_flag_bank.sv */
// sticky event flags, set wins over a software clear
// assumes events are on the pclk domain
module irq_flag_bank #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // events and clears
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clr,
   input  wire logic [WIDTH-1:0] keep,
   // state
   output logic      [WIDTH-1:0] flags
);
   logic [WIDTH-1:0] next_flags;

   if (WIDTH < 1) begin : g_bad_width
      $error("irq_flag_bank: WIDTH must be positive");
   end

   always_comb begin
      next_flags = ((flags & ~clr) | set) & keep;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule : irq_flag_bank

/* File: verilog/periph_irq_enable.sv */
// peripheral interrupt enable and flag registers behind apb
// assumes event inputs are one-cycle pulses from pclk-domain peripherals, except the usart inputs, which are levels
module periph_irq_enable
   import periph_irq_pkg::*;
#(
   parameter bit HAS_USART   = 1'b1,
   parameter bit HAS_PARPORT = 1'b1
) (
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // peripheral events
   input  wire logic        timer_one_ovf,
   input  wire logic        timer_two_match,
   input  wire logic        capcomp_one_evt,
   input  wire logic        sync_serial_evt,
   input  wire logic        usart_tx_ready,
   input  wire logic        usart_rx_ready,
   input  wire logic        parallel_port_evt,
   // to the core
   output logic             periph_irq_req,
   output logic             irq
);
   localparam logic [7:0] IMPL_MASK = BASIC_MASK
      | (HAS_USART ? USART_MASK : 8'h00)
      | (HAS_PARPORT ? PAR_MASK : 8'h00);

   logic [7:0]  periph_irq_enable_reg;
   logic [7:0]  next_enable;
   logic [7:0]  core_irq_control_reg;
   logic [7:0]  next_control;
   logic [1:0]  bus_irq_status;
   logic [1:0]  next_bus_status;
   logic [1:0]  bus_irq_mask;
   logic [1:0]  next_bus_mask;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_req;
   logic        next_irq;
   logic [7:0]  periph_irq_flag_reg;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;
   logic [7:0]  flag_prev;
   logic        wr_acc;
   logic        rd_acc;
   logic        hit;
   logic        periph_master_enable;
   logic        pending;

   assign wr_acc = psel && penable && pwrite && !pready;
   assign rd_acc = psel && penable && !pwrite && !pready;
   assign hit    = paddr == OFS_ENABLE || paddr == OFS_FLAG
      || paddr == OFS_CONTROL || paddr == OFS_BUS_IRQ_STATUS
      || paddr == OFS_BUS_IRQ_MASK;
   assign periph_master_enable = core_irq_control_reg[BIT_MASTER_EN];

   // usart flags are level status in the peripheral, others are pulses
   always_comb begin
      flag_set = 8'h00;
      flag_set[BIT_TIMER_ONE] = timer_one_ovf;
      flag_set[BIT_TIMER_TWO] = timer_two_match;
      flag_set[BIT_CAPCOMP]   = capcomp_one_evt;
      flag_set[BIT_SERIAL]    = sync_serial_evt;
      flag_set[BIT_UTX]  = usart_tx_ready;
      flag_set[BIT_URX]  = usart_rx_ready;
      flag_set[BIT_PAR]  = parallel_port_evt;
      flag_set = flag_set & IMPL_MASK;
      flag_clr = 8'h00;
      if (wr_acc && paddr == OFS_FLAG && pstrb[0]) begin
         flag_clr = ~pwdata[7:0] & ~USART_MASK;
      end
      flag_clr = flag_clr | (USART_MASK & ~flag_set);
   end

   irq_flag_bank #(
      .WIDTH(8)
   ) u_flags (
      .pclk   (pclk),
      .presetn(presetn),
      .set    (flag_set),
      .clr    (flag_clr),
      .keep   (IMPL_MASK),
      .flags  (periph_irq_flag_reg)
   );

   assign pending = |(periph_irq_flag_reg & periph_irq_enable_reg);

   always_comb begin
      next_enable     = periph_irq_enable_reg;
      next_control    = core_irq_control_reg;
      next_bus_mask   = bus_irq_mask;
      next_bus_status = bus_irq_status;
      next_prdata     = prdata;
      next_pready     = 1'b0;
      next_pslverr    = 1'b0;
      if (wr_acc || rd_acc) begin
         next_pready  = 1'b1;
         next_pslverr = !hit;
      end
      if (wr_acc && pstrb[0]) begin
         case (paddr)
            OFS_ENABLE: begin
               next_enable = pwdata[7:0] & IMPL_MASK;
            end
            OFS_CONTROL: begin
               next_control = pwdata[7:0]
                  & (8'h01 << BIT_MASTER_EN | 8'h01 << BIT_GLOBAL_EN);
            end
            OFS_BUS_IRQ_MASK: begin
               next_bus_mask = pwdata[1:0];
            end
            OFS_BUS_IRQ_STATUS: begin
               next_bus_status = bus_irq_status & ~pwdata[1:0];
            end
            default: begin
            end
         endcase
      end
      if (next_req && !periph_irq_req) begin
         next_bus_status = next_bus_status | BUS_EVT_REQ_RISE;
      end
      if (|(periph_irq_flag_reg & ~flag_prev)) begin
         next_bus_status = next_bus_status | BUS_EVT_FLAG_NEW;
      end
      if (rd_acc) begin
         case (paddr)
            OFS_ENABLE:  next_prdata = {24'h0, periph_irq_enable_reg};
            OFS_FLAG:    next_prdata = {24'h0, periph_irq_flag_reg};
            OFS_CONTROL: next_prdata = {24'h0, core_irq_control_reg};
            OFS_BUS_IRQ_STATUS: next_prdata = {30'h0, bus_irq_status};
            OFS_BUS_IRQ_MASK:   next_prdata = {30'h0, bus_irq_mask};
            default:     next_prdata = 32'h0;
         endcase
      end
   end

   always_comb begin
      next_req = pending && periph_master_enable;
      next_irq = |(bus_irq_status & bus_irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_irq_enable_reg <= ENABLE_RESET;
         core_irq_control_reg  <= 8'h00;
         bus_irq_status        <= 2'h0;
         bus_irq_mask          <= 2'h0;
         flag_prev             <= FLAG_RESET;
         prdata                <= 32'h0;
         pready                <= 1'b0;
         pslverr               <= 1'b0;
         periph_irq_req        <= 1'b0;
         irq                   <= 1'b0;
      end else begin
         periph_irq_enable_reg <= next_enable;
         core_irq_control_reg  <= next_control;
         bus_irq_status        <= next_bus_status;
         bus_irq_mask          <= next_bus_mask;
         flag_prev             <= periph_irq_flag_reg;
         prdata                <= next_prdata;
         pready                <= next_pready;
         pslverr               <= next_pslverr;
         periph_irq_req        <= next_req;
         irq                   <= next_irq;
      end
   end

   a_master_gate: assert property (@(posedge pclk)
      disable iff (!presetn)
      !core_irq_control_reg[BIT_MASTER_EN] |=> !periph_irq_req)
      else $error("request passed with master enable clear");

   a_req_forms: assert property (@(posedge pclk)
      disable iff (!presetn)
      (pending && periph_master_enable) |=> periph_irq_req)
      else $error("unmasked pending request not forwarded");

   a_req_cause: assert property (@(posedge pclk)
      disable iff (!presetn)
      periph_irq_req |-> $past(pending))
      else $error("request without enabled flag");

   a_enable_write: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_acc && pstrb[0] && paddr == OFS_ENABLE)
      |=> periph_irq_enable_reg == ($past(pwdata[7:0]) & IMPL_MASK))
      else $error("enable register write lost");

   a_usart_zero: assert property (@(posedge pclk)
      disable iff (!presetn)
      !HAS_USART |-> periph_irq_enable_reg[5:4] == 2'b00)
      else $error("usart enable bits stored without usart");

   a_flag_sets: assert property (@(posedge pclk)
      disable iff (!presetn)
      timer_one_ovf |=> periph_irq_flag_reg[BIT_TIMER_ONE])
      else $error("timer-one flag not set by its event");

   a_flag_sticky: assert property (@(posedge pclk)
      disable iff (!presetn)
      (periph_irq_flag_reg[BIT_SERIAL]
       && !(wr_acc && paddr == OFS_FLAG && pstrb[0]))
      |=> periph_irq_flag_reg[BIT_SERIAL])
      else $error("serial flag cleared without software");

   a_capcomp_gate: assert property (@(posedge pclk)
      disable iff (!presetn)
      (periph_irq_flag_reg == 8'h04 && !periph_irq_enable_reg[BIT_CAPCOMP])
      |=> !periph_irq_req)
      else $error("capture flag passed while disabled");

   a_one_cycle: assert property (@(posedge pclk)
      disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   // no disable here, so the reset value itself is covered
   a_reset_clear: assert property (@(posedge pclk)
      $past(!presetn) |-> periph_irq_enable_reg == ENABLE_RESET)
      else $error("enable register not clear after reset");

   a_unimpl_clear: assert property (@(posedge pclk)
      disable iff (!presetn)
      (periph_irq_enable_reg & ~IMPL_MASK) == 8'h00)
      else $error("enable bit stored without its source");

   a_flag_unimpl: assert property (@(posedge pclk)
      disable iff (!presetn)
      (periph_irq_flag_reg & ~IMPL_MASK) == 8'h00)
      else $error("flag stored without its source");

   a_enable_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_acc && paddr == OFS_ENABLE)
      |=> prdata == {24'h0, $past(periph_irq_enable_reg)})
      else $error("enable register read back wrong");

   a_enable_hold: assert property (@(posedge pclk)
      disable iff (!presetn)
      !(wr_acc && pstrb[0] && paddr == OFS_ENABLE)
      |=> $stable(periph_irq_enable_reg))
      else $error("enable register changed without a write");

   a_match_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      timer_two_match |=> periph_irq_flag_reg[BIT_TIMER_TWO])
      else $error("timer-two flag not set by its event");

   a_capture_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      capcomp_one_evt |=> periph_irq_flag_reg[BIT_CAPCOMP])
      else $error("capture flag not set by its event");

   a_serial_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      sync_serial_evt |=> periph_irq_flag_reg[BIT_SERIAL])
      else $error("serial flag not set by its event");

   a_tx_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      (HAS_USART && usart_tx_ready) |=> periph_irq_flag_reg[BIT_UTX])
      else $error("transmit flag not set by its level");

   a_rx_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      (HAS_USART && usart_rx_ready) |=> periph_irq_flag_reg[BIT_URX])
      else $error("receive flag not set by its level");

   a_parport_flag: assert property (@(posedge pclk)
      disable iff (!presetn)
      (HAS_PARPORT && parallel_port_evt) |=> periph_irq_flag_reg[BIT_PAR])
      else $error("parallel port flag not set by its event");

   a_flag_clear: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_acc && pstrb[0] && paddr == OFS_FLAG && !pwdata[BIT_SERIAL]
       && !sync_serial_evt) |=> !periph_irq_flag_reg[BIT_SERIAL])
      else $error("software clear of the serial flag lost");

   a_req_drop: assert property (@(posedge pclk)
      disable iff (!presetn)
      !pending |=> !periph_irq_req)
      else $error("request without any enabled flag");

   a_ready_answer: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_acc || rd_acc) |=> pready)
      else $error("access phase not answered");

   a_slverr_pair: assert property (@(posedge pclk)
      disable iff (!presetn)
      pslverr |-> pready)
      else $error("slave error outside a response");

   a_slverr_hit: assert property (@(posedge pclk)
      disable iff (!presetn)
      ((wr_acc || rd_acc) && !hit) |=> pslverr)
      else $error("unmapped access not flagged");

   a_control_bits: assert property (@(posedge pclk)
      disable iff (!presetn)
      (core_irq_control_reg
       & ~(8'h01 << BIT_MASTER_EN | 8'h01 << BIT_GLOBAL_EN)) == 8'h00)
      else $error("undefined control bit stored");

   a_status_rise: assert property (@(posedge pclk)
      disable iff (!presetn)
      (next_req && !periph_irq_req) |=> bus_irq_status[0])
      else $error("request rise not recorded");

   a_irq_level: assert property (@(posedge pclk)
      disable iff (!presetn)
      (|(bus_irq_status & bus_irq_mask)) |=> irq)
      else $error("unmasked bus event not signalled");

   a_irq_quiet: assert property (@(posedge pclk)
      disable iff (!presetn)
      !(|(bus_irq_status & bus_irq_mask)) |=> !irq)
      else $error("bus interrupt without unmasked event");
endmodule : periph_irq_enable

/* File: tb/periph_evt_source.sv */
// stand-in for the peripherals feeding the interrupt block
// assumes evt changes just after pclk rising edges
module periph_evt_source (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // wanted conditions, one bit per enable position
   input  wire logic [7:0] evt,
   // event lines
   output logic      [7:0] line
);
   logic [7:0] prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 8'h00;
         line <= 8'h00;
      end else begin
         prev <= evt;
         // usart lines are levels, the others strictly one-cycle pulses
         line <= (evt & ~prev & 8'hCF) | (evt & 8'h30);
      end
   end
endmodule : periph_evt_source

/* File: tb/test_periph_irq_enable.sv */
// self-checking bench for the peripheral interrupt enable block
// assumes an apb slave answering with pready, events from a stand-in
module test_periph_irq_enable
   import periph_irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, sel_b;
   logic        pready, pslverr, req, irq, err;
   logic [11:0] paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, prdata_b, rd, rdb;
   logic [7:0]  evt, line;
   int          err_count, checks, cyc, i;

   periph_evt_source periph_evt_source_i (.pclk, .presetn, .evt, .line);
   periph_irq_enable periph_irq_enable_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .timer_one_ovf(line[0]), .timer_two_match(line[1]),
      .capcomp_one_evt(line[2]), .sync_serial_evt(line[3]),
      .usart_tx_ready(line[4]), .usart_rx_ready(line[5]),
      .parallel_port_evt(line[7]), .periph_irq_req(req), .irq);
   // bare variant: no usart, no parallel port
   periph_irq_enable #(.HAS_USART(1'b0), .HAS_PARPORT(1'b0))
      periph_irq_enable_basic_i (.pclk, .presetn, .psel(psel & sel_b),
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata_b),
      .pready(), .pslverr(), .timer_one_ovf(line[0]),
      .timer_two_match(line[1]), .capcomp_one_evt(line[2]),
      .sync_serial_evt(line[3]), .usart_tx_ready(line[4]),
      .usart_rx_ready(line[5]), .parallel_port_evt(line[7]),
      .periph_irq_req(), .irq());

   always #5 pclk = ~pclk;

   task automatic close_out;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; waits for pready, then checks that it came after two cycles
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      rdb = prdata_b;
      err = pslverr;
      // one wait state, then the answer
      chk(32'(n), 32'h2);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; sel_b = 1;
      paddr = 0; pwdata = 0; evt = 0; err_count = 0; checks = 0; cyc = 0;
      pstrb = 4'hF;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, OFS_ENABLE, 0);
      chk(rd, 32'h0);
      chk(rdb, 32'h0);
      xfer(1, OFS_ENABLE, 32'h3F);
      xfer(0, OFS_ENABLE, 0);
      chk(rd, 32'h3F);
      chk(rdb, 32'h0F);
      // a write with lane 0 off must leave the register alone
      pstrb <= 4'h0;
      xfer(1, OFS_ENABLE, 32'h00);
      pstrb <= 4'hF;
      xfer(0, OFS_ENABLE, 0);
      chk(rd, 32'h3F);
      sel_b <= 1'b0;
      xfer(0, 12'h200, 0);
      chk({rd[31:1], err}, 32'h1);
      for (i = 0; i < 8; i++) if (i != 6) begin
         // master on, so only the source's own enable can hold it back
         xfer(1, OFS_CONTROL, 32'h40);
         // all other sources enabled, bit 6 kept clear
         xfer(1, OFS_ENABLE, 32'hBF & ~(32'h1 << i));
         evt[i] <= 1'b1;
         repeat (4) @(posedge pclk);
         chk(32'(req), 32'h0);
         xfer(0, OFS_FLAG, 0);
         chk(32'(rd[i]), 32'h1);
         xfer(1, OFS_CONTROL, 32'h00);
         xfer(1, OFS_ENABLE, 32'h1 << i);
         repeat (3) @(posedge pclk);
         chk(32'(req), 32'h0);
         xfer(1, OFS_CONTROL, 32'h40);
         repeat (20) @(posedge pclk);
         chk(32'(req), 32'h1);
         evt <= 8'h00;
         // stale flag dropped before the next source is armed
         xfer(1, OFS_FLAG, 32'hFF & ~(32'h1 << i));
         repeat (3) @(posedge pclk);
         chk(32'(req), 32'h0);
      end
      xfer(0, OFS_BUS_IRQ_STATUS, 0);
      chk(rd, 32'h3);
      chk(32'(irq), 32'h0);
      xfer(1, OFS_BUS_IRQ_MASK, 32'h3);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1);
      xfer(1, OFS_BUS_IRQ_STATUS, 32'h3);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      close_out();
   end
endmodule : test_periph_irq_enable
